// ==== rtl/gpioei_top.sv ====
`timescale 1ns/10ps
// Function
// - One 8-bit register holds a 2-bit mode per port, shared by its pins.
// - Reset clears the mode register, all ports undriven.
// - Data bit zero drives the pin low in every mode.
// - Data one with mode 10 drives the pin high.
// - Data one with mode 11 pulls the pin up weakly.
// - Data one with mode 00 or 01 leaves the pin undriven.
// - Mode 00 detects rising edges; modes 01 and 11 falling edges.
// - Mode 10 ports never raise pin interrupts.
// - Interrupt needs pin enable, global enable, sense bit 2 and an edge.
// - Pull-up mode reads high unless pulled low externally.
// - Undriven mode reads the actual pin level.
// - Four write-only per-pin interrupt enable registers; one enables.
// - Reset clears all pin interrupt enables.
// - Parallel host mode blocks every pin interrupt.
// - All qualified pin events merge into one shared request.
// - Reset sets every port data bit to one.
// - Without parallel mode, port reads return present pin levels.
module gpioei_top (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Pins: level in, drive value, enable low while driven
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe_n,
    output logic [31:0] pin_pullup,
    // Interrupt
    output logic irq
);
    logic [7:0] data_reg [4];
    logic [7:0] irq_en_reg [4];
    logic [7:0] mode_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] mask_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [31:0] out_reg;
    logic [31:0] oe_n_reg;
    logic [31:0] pull_reg;
    logic irq_reg;
    logic [31:0] pin_level;
    logic [3:0] port_hit;
    logic any_event;
    logic global_en;
    logic sense_en;
    logic parallel_on;
    logic [7:0] stat_set;
    logic [7:0] stat_clr;
    logic [31:0] drv_out;
    logic [31:0] drv_oe_n;
    logic [31:0] drv_pull;
    logic wr_mode;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;

    assign global_en = ctrl_reg[gpioei_pkg::CTRL_GLOBAL_EN_BIT];
    assign sense_en = ctrl_reg[gpioei_pkg::CTRL_SENSE_BIT];
    assign parallel_on = ctrl_reg[gpioei_pkg::CTRL_PARALLEL_BIT];
    assign wr_mode = reg_write && (reg_addr == gpioei_pkg::PORT_MODE_SELECT_ADDR);
    assign wr_ctrl = reg_write && (reg_addr == gpioei_pkg::IRQ_CTRL_ADDR);
    assign wr_status = reg_write && (reg_addr == gpioei_pkg::IRQ_STATUS_ADDR);
    assign wr_mask = reg_write && (reg_addr == gpioei_pkg::IRQ_MASK_ADDR);

    genvar p;
    generate
        for (p = 0; p < gpioei_pkg::NUM_PORTS; p++) begin : g_port
            gpioei_pin_if pif ();
            logic [1:0] mode;
            logic [7:0] qual;
            logic [7:0] edges;
            logic [7:0] data;

            gpioei_port_sync u_sync (
                .clk(clk),
                .reset(reset),
                .pin_in(pin_in[p*8 +: 8]),
                .pins(pif.sync)
            );

            assign mode = mode_reg[p*2 +: 2];
            assign data = data_reg[p];
            // Edge polarity per port mode
            assign edges = (mode == gpioei_pkg::GPIOEI_MODE_UNDRIVEN_RISE) ? pif.rise :
                           (mode == gpioei_pkg::GPIOEI_MODE_CMOS) ? 8'h00 :
                           pif.fall;
            assign qual = edges & irq_en_reg[p];
            assign port_hit[p] = |qual;
            // Read back the synchronised pin, which reflects pull-up or external level
            assign pin_level[p*8 +: 8] = pif.pin_sync;
            // Low always driven; high only in mode 10
            assign drv_out[p*8 +: 8] = data & {8{mode == gpioei_pkg::GPIOEI_MODE_CMOS}};
            assign drv_oe_n[p*8 +: 8] = data & {8{mode != gpioei_pkg::GPIOEI_MODE_CMOS}};
            assign drv_pull[p*8 +: 8] = data & {8{mode == gpioei_pkg::GPIOEI_MODE_PULLUP}};
        end
    endgenerate

    // Parallel host mode gates all ports, used or not
    assign any_event = (|port_hit) && global_en && sense_en && !parallel_on;
    assign stat_set = {7'h00, any_event};
    assign stat_clr = wr_status ? reg_wdata : 8'h00;
    // Set wins over a simultaneous clear
    assign status_next = (status_reg & ~stat_clr) | stat_set;

    // Read mux; enable registers are write-only and read zero
    always_comb begin
        rdata_next = gpioei_pkg::RDATA_UNMAPPED;
        if (reg_read) begin
            case (reg_addr)
                gpioei_pkg::PORT0_DATA_ADDR: rdata_next = pin_level[7:0];
                gpioei_pkg::PORT1_DATA_ADDR: rdata_next = pin_level[15:8];
                gpioei_pkg::PORT2_DATA_ADDR: rdata_next = pin_level[23:16];
                gpioei_pkg::PORT3_DATA_ADDR: rdata_next = pin_level[31:24];
                gpioei_pkg::PORT_MODE_SELECT_ADDR: rdata_next = mode_reg;
                gpioei_pkg::IRQ_CTRL_ADDR: rdata_next = ctrl_reg;
                gpioei_pkg::IRQ_STATUS_ADDR: rdata_next = status_reg;
                gpioei_pkg::IRQ_MASK_ADDR: rdata_next = mask_reg;
                default: rdata_next = gpioei_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < gpioei_pkg::NUM_PORTS; i++) begin
                data_reg[i] <= gpioei_pkg::DATA_RESET;
                irq_en_reg[i] <= gpioei_pkg::IRQ_EN_RESET;
            end
        end else if (reg_write) begin
            for (int i = 0; i < gpioei_pkg::NUM_PORTS; i++) begin
                if (reg_addr == gpioei_pkg::PORT0_DATA_ADDR + 8'(i)) begin
                    data_reg[i] <= reg_wdata;
                end
                // Bit 7 of port 3 is stored as written; software keeps it zero
                if (reg_addr == gpioei_pkg::PORT0_IRQ_EN_ADDR + 8'(i)) begin
                    irq_en_reg[i] <= reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg <= gpioei_pkg::MODE_RESET;
            ctrl_reg <= gpioei_pkg::CTRL_RESET;
            mask_reg <= gpioei_pkg::MASK_RESET;
            status_reg <= gpioei_pkg::STATUS_RESET;
        end else begin
            if (wr_mode) begin
                mode_reg <= reg_wdata;
            end
            if (wr_ctrl) begin
                ctrl_reg <= reg_wdata;
            end
            if (wr_mask) begin
                mask_reg <= reg_wdata;
            end
            status_reg <= status_next;
        end
    end

    // Outputs registered; pins change one cycle after a write
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg <= 8'h00;
            out_reg <= 32'h0000_0000;
            oe_n_reg <= 32'hFFFF_FFFF;
            pull_reg <= 32'h0000_0000;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            out_reg <= drv_out;
            oe_n_reg <= drv_oe_n;
            pull_reg <= drv_pull;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    assign reg_rdata = rdata_reg;
    assign pin_out = out_reg;
    assign pin_oe_n = oe_n_reg;
    assign pin_pullup = pull_reg;
    assign irq = irq_reg;
endmodule // gpioei_top

// ==== rtl/gpioei_pkg.sv ====
package gpioei_pkg;
    // Register indices on the plain port (byte addresses)
    localparam logic [7:0] PORT0_DATA_ADDR = 8'h00;
    localparam logic [7:0] PORT1_DATA_ADDR = 8'h01;
    localparam logic [7:0] PORT2_DATA_ADDR = 8'h02;
    localparam logic [7:0] PORT3_DATA_ADDR = 8'h03;
    localparam logic [7:0] PORT_MODE_SELECT_ADDR = 8'h08;
    localparam logic [7:0] PORT0_IRQ_EN_ADDR = 8'h04;
    localparam logic [7:0] PORT1_IRQ_EN_ADDR = 8'h05;
    localparam logic [7:0] PORT2_IRQ_EN_ADDR = 8'h06;
    localparam logic [7:0] PORT3_IRQ_EN_ADDR = 8'h07;
    localparam logic [7:0] IRQ_CTRL_ADDR = 8'h0A;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0B;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h0C;
    // Control register fields
    localparam int CTRL_GLOBAL_EN_BIT = 0;
    localparam int CTRL_SENSE_BIT = 2;
    localparam int CTRL_PARALLEL_BIT = 4;
    // Status fields
    localparam int STAT_PIN_EVENT_BIT = 0;
    // Reset values
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // Port modes
    typedef enum logic [1:0] {
        GPIOEI_MODE_UNDRIVEN_RISE = 2'h0,
        GPIOEI_MODE_UNDRIVEN_FALL = 2'h1,
        GPIOEI_MODE_CMOS = 2'h2,
        GPIOEI_MODE_PULLUP = 2'h3
    } gpioei_mode_t;
    localparam int NUM_PORTS = 4;
    localparam int PORT_WIDTH = 8;
endpackage

// ==== rtl/gpioei_pin_if.sv ====
`timescale 1ns/10ps
interface gpioei_pin_if;
    logic [7:0] pin_sync;
    logic [7:0] rise;
    logic [7:0] fall;
    modport sync (output pin_sync, output rise, output fall);
    modport core (input pin_sync, input rise, input fall);
endinterface

// ==== rtl/gpioei_port_sync.sv ====
`timescale 1ns/10ps
module gpioei_port_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Raw pin levels
    input wire logic [7:0] pin_in,
    // Synchronised levels and edges
    gpioei_pin_if.sync pins
);
    logic [7:0] s1_reg;
    logic [7:0] s2_reg;
    logic [7:0] s3_reg;
    logic [7:0] level_reg;
    logic [7:0] agree;
    logic [7:0] level_next;

    // Change counts only when the two later stages agree
    assign agree = ~(s2_reg ^ s3_reg);
    assign level_next = (agree & s3_reg) | (~agree & level_reg);

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_reg <= 8'hFF;
            s2_reg <= 8'hFF;
            s3_reg <= 8'hFF;
            level_reg <= 8'hFF;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign pins.pin_sync = level_reg;
    // One event per edge of the filtered level
    assign pins.rise = level_next & ~level_reg;
    assign pins.fall = ~level_next & level_reg;
endmodule // gpioei_port_sync

// ==== test/gpioei_ext_pins.sv ====
`timescale 1ns/10ps
module gpioei_ext_pins (
    // Clock
    input wire logic clk,
    // Device drive
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] pin_pullup,
    // External sources
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    // Resolved level
    output logic [31:0] pin_lvl
);
    logic [31:0] float_reg = 32'h0000_0000;
    // Floating pins wander, so a stale level never passes for a drive
    always_ff @(posedge clk) float_reg <= ~float_reg;
    // External source overdrives the device
    assign pin_lvl = (ext_en & ext_val) | (~ext_en & ~pin_oe_n & pin_out)
        | (~ext_en & pin_oe_n & (pin_pullup | float_reg));
endmodule // gpioei_ext_pins

// ==== test/gpioei_monitor.sv ====
`timescale 1ns/10ps
module gpioei_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Pins and interrupt
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] pin_pullup,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    logic [7:0] mode_reg;
    logic [7:0] ctrl_reg;
    logic [31:0] data_reg;
    wire mask_wr = reg_write && reg_addr == gpioei_pkg::IRQ_MASK_ADDR;
    wire zero_rd = reg_read && (reg_addr[7:2] == 6'h01 || reg_addr == 8'h09 || reg_addr > 8'h0C);
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_reg <= 8'h00;
            ctrl_reg <= 8'h00;
            data_reg <= 32'hFFFF_FFFF;
        end else if (reg_write) begin
            if (reg_addr == gpioei_pkg::PORT_MODE_SELECT_ADDR) mode_reg <= reg_wdata;
            if (reg_addr == gpioei_pkg::IRQ_CTRL_ADDR) ctrl_reg <= reg_wdata;
            if (reg_addr < 8'h04) data_reg[reg_addr[1:0] * 8 +: 8] <= reg_wdata;
        end
    end
    reset_drive_a: assert property (reset |=> pin_oe_n == 32'hFFFF_FFFF && irq == 1'b0)
        else $error("outputs not idle after reset");
    pull_excl_a: assert property (disable iff (reset) (pin_pullup & ~pin_oe_n) == 32'h0000_0000)
        else $error("pull-up on while driving");
    drive_low_a: assert property (disable iff (reset)
        ((~data_reg & ~$past(data_reg)) & (pin_oe_n | pin_out)) == 32'h0000_0000)
        else $error("zero data bit not driven low");
    mode_back_a: assert property (disable iff (reset)
        reg_read && reg_addr == gpioei_pkg::PORT_MODE_SELECT_ADDR |=> reg_rdata == mode_reg)
        else $error("mode register readback wrong");
    wo_zero_a: assert property (disable iff (reset) zero_rd |=> reg_rdata == 8'h00)
        else $error("write-only or unmapped read not zero");
    irq_gate_a: assert property (disable iff (reset) $rose(irq) && !$past(mask_wr)
        && !$past(mask_wr, 2) |-> $past(ctrl_reg[0]) && $past(ctrl_reg[2]) && !$past(ctrl_reg[4]))
        else $error("interrupt raised while gated");
    for (genvar p = 0; p < 4; p++) begin : g_port
        port_uniform_a: assert property (disable iff (reset)
            !(|(pin_out[p*8 +: 8] & ~pin_oe_n[p*8 +: 8]) && |pin_pullup[p*8 +: 8]))
            else $error("mixed modes within one port");
        cmos_high_a: assert property (disable iff (reset) mode_reg[2*p +: 2] == 2'b10
            && $past(mode_reg[2*p +: 2]) == 2'b10 |-> ((pin_oe_n[p*8 +: 8] | ~pin_out[p*8 +: 8])
            & data_reg[p*8 +: 8] & $past(data_reg[p*8 +: 8])) == 8'h00)
            else $error("output high not driven");
    end
endmodule // gpioei_monitor
bind gpioei_top gpioei_monitor u_monitor (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .irq(irq));

// ==== test/gpio_port_config_and_edge_irq_test.sv ====
`timescale 1ns/10ps
module gpio_port_config_and_edge_irq_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic rd_seen = 1'b0;
    logic [31:0] ext_en = 32'h0000_0000;
    logic [31:0] ext_val = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_6112;
    logic [7:0] ctl [4] = '{8'h05, 8'h01, 8'h04, 8'h15};
    logic [7:0] cur_mask;
    logic [7:0] exp_q [$];
    logic [7:0] msk_q [$];
    logic [7:0] reg_rdata;
    logic [31:0] pin_in, pin_out, pin_oe_n, pin_pullup;
    logic irq;
    int err_count = 0;
    int total_checks = 0;
    always #50 clk = ~clk;
    gpioei_top DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .irq(irq));
    gpioei_ext_pins far_end (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
    endtask
    task automatic chk_irq(input logic e);
        #1;
        check({7'h00, irq}, {7'h00, e});
    endtask
    // Read data stands one cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            cur_mask = msk_q.pop_front();
            check(reg_rdata & cur_mask, exp_q.pop_front() & cur_mask);
        end
        rd_seen <= reg_read;
    end
    initial begin
        tick(20000);
        err_count++;
        end_sim();
    end
    initial begin
        int i;
        int b;
        tick(5);
        reset <= 1'b0;
        ext_en <= 32'hFFFF_FFFF;
        ext_val <= seed;
        tick(6);
        for (i = 0; i < 4; i++) begin
            rd(8'(i), seed[i*8 +: 8], 8'hFF);
            rd(8'(i + 4), 8'h00, 8'hFF);
        end
        rd(gpioei_pkg::PORT_MODE_SELECT_ADDR, 8'h00, 8'hFF);
        rd(8'h0F, 8'h00, 8'hFF);
        wr(gpioei_pkg::IRQ_MASK_ADDR, 8'h01);
        // First pass leaves enables at reset value; later passes gate by control
        for (i = 0; i < 4; i++) begin
            if (i == 1) wr(gpioei_pkg::PORT0_IRQ_EN_ADDR, 8'h01);
            wr(gpioei_pkg::IRQ_CTRL_ADDR, ctl[i]);
            ext_val[0] <= 1'b0;
            tick(6);
            ext_val[0] <= 1'b1;
            tick(6);
            rd(gpioei_pkg::IRQ_STATUS_ADDR, 8'h00, 8'h01);
        end
        wr(gpioei_pkg::PORT0_DATA_ADDR, 8'h0F);
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(gpioei_pkg::PORT_MODE_SELECT_ADDR, {4{i[1:0]}});
            ext_en <= 32'h0000_00C0;
            ext_val <= seed;
            tick(6);
            rd(gpioei_pkg::PORT_MODE_SELECT_ADDR, {4{i[1:0]}}, 8'hFF);
            rd(8'h00, {seed[7:6], 6'h0F}, (i < 2) ? 8'hF0 : 8'hFF);
        end
        wr(gpioei_pkg::PORT0_DATA_ADDR, 8'hFF);
        wr(gpioei_pkg::IRQ_CTRL_ADDR, 8'h05);
        // Pass p sets every port to mode p and tests port p; bit 7 of port 3 stays clear
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            b = i * 8 + seed[2:0] % 7;
            wr(8'(gpioei_pkg::PORT0_IRQ_EN_ADDR + i), 8'h01 << (b % 8));
            wr(gpioei_pkg::PORT_MODE_SELECT_ADDR, {4{i[1:0]}});
            ext_en <= 32'h0000_0001 << b;
            ext_val <= {32{i == 0}};
            tick(6);
            wr(gpioei_pkg::IRQ_STATUS_ADDR, 8'h01);
            ext_val <= ~ext_val;
            tick(6);
            rd(gpioei_pkg::IRQ_STATUS_ADDR, 8'h00, 8'h01);
            ext_val <= ~ext_val;
            tick(6);
            rd(gpioei_pkg::IRQ_STATUS_ADDR, {7'h00, i != 2}, 8'h01);
            chk_irq(i != 2);
            wr(gpioei_pkg::IRQ_MASK_ADDR, 8'h00);
            tick(2);
            chk_irq(1'b0);
            wr(gpioei_pkg::IRQ_MASK_ADDR, 8'h01);
            wr(gpioei_pkg::IRQ_STATUS_ADDR, 8'h01);
            tick(2);
            chk_irq(1'b0);
        end
        tick(3);
        end_sim();
    end
endmodule // gpio_port_config_and_edge_irq_test
